// *** hdl/vmfc_pkg.sv ***
// Package for the auxiliary monitor and fault counter pair.
// Assumes a single 40 MHz clock and an active-low asynchronous reset.
package vmfc_pkg;
   localparam int unsigned CLK_MHZ = 40;
   // Deglitch times in microseconds
   localparam int unsigned OV_DGLT_US_0 = 25;
   localparam int unsigned OV_DGLT_US_1 = 45;
   localparam int unsigned UV_DGLT_US_0 = 5;
   localparam int unsigned UV_DGLT_US_1 = 15;
   localparam int unsigned UV_DGLT_US_2 = 25;
   localparam int unsigned UV_DGLT_US_3 = 40;
   localparam logic [11:0] OV_DGLT_CYC_0 = 12'(OV_DGLT_US_0 * CLK_MHZ);
   localparam logic [11:0] OV_DGLT_CYC_1 = 12'(OV_DGLT_US_1 * CLK_MHZ);
   localparam logic [11:0] UV_DGLT_CYC_0 = 12'(UV_DGLT_US_0 * CLK_MHZ);
   localparam logic [11:0] UV_DGLT_CYC_1 = 12'(UV_DGLT_US_1 * CLK_MHZ);
   localparam logic [11:0] UV_DGLT_CYC_2 = 12'(UV_DGLT_US_2 * CLK_MHZ);
   localparam logic [11:0] UV_DGLT_CYC_3 = 12'(UV_DGLT_US_3 * CLK_MHZ);
   // Threshold codes: code 0 is 4.5 %, step 0.5 %, code 15 is 12 %
   localparam logic [7:0] THR_CODE_MAX = 8'h0f;
   // Reset values of the host-written fields and the fault counter; counter limits
   localparam logic [1:0] OV_IMPACT_RST = 2'h2;
   localparam logic [1:0] UV_IMPACT_RST = 2'h1;
   localparam logic [1:0] LIMIT_RST = 2'h1;
   localparam logic [2:0] REG_SEL_RST = 3'h0;
   localparam logic [3:0] CNT_RST = 4'h1;
   localparam logic [3:0] LIMIT_2 = 4'h2;
   localparam logic [3:0] LIMIT_6 = 4'h6;
   localparam logic [3:0] LIMIT_8 = 4'h8;
   localparam logic [3:0] LIMIT_12 = 4'hc;
   // Regulator select: 0 means external, cannot be switched off
   localparam logic [2:0] REG_EXTERNAL = 3'h0;
endpackage

// *** hdl/vmfc_link_if.sv ***
// Link between the host controller and the monitor device.
// Assumes both ends share pclk; the host writes settings as plain strobes.
`timescale 1ns/1ps
interface vmfc_link_if;
   logic cfg_we;
   logic [1:0] ov_impact;
   logic [1:0] uv_impact;
   logic [1:0] limit;
   logic [2:0] reg_sel;
   logic init_done;
   logic pulse_req;
   logic reset_output_low;
   logic power_good_output;
   logic ov_flag;
   logic uv_flag;
   logic [3:0] fault_count;
   logic deep_failsafe_state;
   modport device (input cfg_we, ov_impact, uv_impact, limit, reg_sel, init_done,
      pulse_req, output reset_output_low, power_good_output, ov_flag, uv_flag,
      fault_count, deep_failsafe_state);
   modport host (output cfg_we, ov_impact, uv_impact, limit, reg_sel, init_done,
      pulse_req, input reset_output_low, power_good_output, ov_flag, uv_flag,
      fault_count, deep_failsafe_state);
endinterface

// *** hdl/vmfc_device.sv ***
// Auxiliary voltage monitor, reset and power-good reaction, fault counter.
// Assumes comparator and fault inputs synchronous to pclk.
//
// Implementation choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
module vmfc_device
   import vmfc_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   vmfc_link_if.device link,
   input wire logic aux_enable_fuse,
   input wire logic [7:0] aux_ov_threshold_fuse,
   input wire logic [7:0] aux_uv_threshold_fuse,
   input wire logic aux_ov_deglitch_fuse,
   input wire logic [1:0] aux_uv_deglitch_fuse,
   input wire logic aux_ov_pg_fuse,
   input wire logic aux_uv_pg_fuse,
   input wire logic power_good_follows_reset,
   input wire logic [7:0] aux_level_pct2,
   input wire logic core_io_fault_rst,
   input wire logic core_io_fault_pg,
   input wire logic ext_reset_low,
   input wire logic reset_short_high,
   input wire logic register_corruption_flag,
   input wire logic fuse_corruption_flag,
   input wire logic standby_resume,
   output logic [2:0] regulator_off
);
   import vmfc_pkg::*;

   logic [1:0] ov_imp_q, uv_imp_q, lim_q;
   logic [2:0] reg_sel_q;
   logic [11:0] ov_cnt_q, uv_cnt_q, ov_need, uv_need;
   logic ov_raw, uv_raw, ov_q, uv_q, ov_rise, uv_rise;
   logic [7:0] ov_code, uv_code;
   logic [3:0] cnt_q, cnt_max;
   logic deep_q, rst_q, pg_q, fault_pulse;
   logic ov_rst, uv_rst, ov_pg, uv_pg, rst_d, pg_d;

   // Settings latched only while the init phase is open
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ov_imp_q <= OV_IMPACT_RST;
         uv_imp_q <= UV_IMPACT_RST;
         lim_q <= LIMIT_RST;
         reg_sel_q <= REG_SEL_RST;
      end else if (link.cfg_we && !link.init_done) begin
         ov_imp_q <= link.ov_impact;
         uv_imp_q <= link.uv_impact;
         lim_q <= link.limit;
         reg_sel_q <= link.reg_sel;
      end
   end

   // Level given in half-percent units of deviation from nominal
   always_comb begin
      ov_code = (aux_ov_threshold_fuse > THR_CODE_MAX) ? THR_CODE_MAX
                : aux_ov_threshold_fuse;
      uv_code = (aux_uv_threshold_fuse > THR_CODE_MAX) ? THR_CODE_MAX
                : aux_uv_threshold_fuse;
      ov_raw = aux_enable_fuse && (aux_level_pct2 >= 8'(ov_code + 8'h09));
      uv_raw = aux_enable_fuse && (aux_level_pct2 >= 8'h80) &&
               ((8'(8'h00 - aux_level_pct2)) >= 8'(uv_code + 8'h09));
      ov_need = aux_ov_deglitch_fuse ? OV_DGLT_CYC_1 : OV_DGLT_CYC_0;
      case (aux_uv_deglitch_fuse)
         2'h0: uv_need = UV_DGLT_CYC_0;
         2'h1: uv_need = UV_DGLT_CYC_1;
         2'h2: uv_need = UV_DGLT_CYC_2;
         default: uv_need = UV_DGLT_CYC_3;
      endcase
   end

   // Deglitch counters; a glitch restarts the count
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ov_cnt_q <= 12'h000;
         uv_cnt_q <= 12'h000;
         ov_q <= 1'b0;
         uv_q <= 1'b0;
      end else begin
         ov_cnt_q <= !ov_raw ? 12'h000 : (ov_cnt_q < ov_need ? ov_cnt_q + 12'h001 : ov_cnt_q);
         uv_cnt_q <= !uv_raw ? 12'h000 : (uv_cnt_q < uv_need ? uv_cnt_q + 12'h001 : uv_cnt_q);
         ov_q <= ov_raw && (ov_cnt_q >= ov_need - 12'h001);
         uv_q <= uv_raw && (uv_cnt_q >= uv_need - 12'h001);
      end
   end

   assign ov_rise = ov_raw && (ov_cnt_q == ov_need - 12'h001);
   assign uv_rise = uv_raw && (uv_cnt_q == uv_need - 12'h001);

   // Flag reported only for a non-external regulator
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         regulator_off <= 3'h0;
      end else if (ov_q && reg_sel_q != REG_EXTERNAL) begin
         regulator_off <= reg_sel_q;
      end
   end

   always_comb begin
      ov_rst = ov_q && ov_imp_q[1];
      uv_rst = uv_q && uv_imp_q[1];
      ov_pg = ov_q && (aux_ov_pg_fuse || (power_good_follows_reset && ov_imp_q[1]));
      uv_pg = uv_q && (aux_uv_pg_fuse || (power_good_follows_reset && uv_imp_q[1]));
      // corruption and pin faults drop power-good only through deep_q, once the count reaches its limit
      pg_d = !(ov_pg || uv_pg || core_io_fault_pg || deep_q ||
               (power_good_follows_reset && core_io_fault_rst));
      rst_d = pg_d && !(ov_rst || uv_rst || core_io_fault_rst || link.pulse_req);
      fault_pulse = (rst_q && ((ov_rise && ov_imp_q[1]) || (uv_rise && uv_imp_q[1])))
                    || ext_reset_low || reset_short_high
                    || register_corruption_flag || fuse_corruption_flag;
      case (lim_q)
         2'h0: cnt_max = LIMIT_2;
         2'h1: cnt_max = LIMIT_6;
         2'h2: cnt_max = LIMIT_8;
         default: cnt_max = LIMIT_12;
      endcase
   end

   // Outputs are released high; both low during reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rst_q <= 1'b0;
         pg_q <= 1'b0;
      end else begin
         rst_q <= rst_d;
         pg_q <= pg_d;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= CNT_RST;
      end else if (standby_resume) begin
         cnt_q <= CNT_RST;
      end else if (fault_pulse && cnt_q < cnt_max) begin
         cnt_q <= cnt_q + 4'h1;
      end
   end

   // Deep fail-safe is held until a power-on reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         deep_q <= 1'b0;
      end else if (cnt_q >= cnt_max) begin
         deep_q <= 1'b1;
      end
   end

   assign link.reset_output_low = rst_q;
   assign link.power_good_output = pg_q;
   assign link.ov_flag = ov_q;
   assign link.uv_flag = uv_q;
   assign link.fault_count = cnt_q;
   assign link.deep_failsafe_state = deep_q;
endmodule

// *** hdl/vmfc_host.sv ***
// Host end: APB registers drive settings and pulse requests onto the link.
// Assumes an APB master on pclk; slave answers with zero wait states.
`timescale 1ns/1ps
module vmfc_host
   import vmfc_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   vmfc_link_if.host link,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr
);
   import vmfc_pkg::*;

   // Register map of this controller
   localparam logic [7:0] OFS_CFG = 8'h00;
   localparam logic [7:0] OFS_CTRL = 8'h04;
   localparam logic [7:0] OFS_STAT = 8'h08;

   logic [8:0] cfg_q;
   logic init_done_q, pulse_q, cfg_we_q;
   logic wr;

   assign wr = psel && penable && pwrite;
   assign pready = 1'b1;
   assign pslverr = psel && penable && !(paddr == OFS_CFG || paddr == OFS_CTRL
                    || paddr == OFS_STAT);

   // Config write forwards once; ignored by the device after init
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_q <= {REG_SEL_RST, LIMIT_RST, UV_IMPACT_RST, OV_IMPACT_RST};
         cfg_we_q <= 1'b0;
      end else begin
         cfg_we_q <= wr && paddr == OFS_CFG;
         if (wr && paddr == OFS_CFG) begin
            cfg_q <= pwdata[8:0];
         end
      end
   end

   // Init phase closes once and stays closed; pulse lasts one cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         init_done_q <= 1'b0;
         pulse_q <= 1'b0;
      end else begin
         pulse_q <= wr && paddr == OFS_CTRL && pwdata[1];
         if (wr && paddr == OFS_CTRL && pwdata[0]) begin
            init_done_q <= 1'b1;
         end
      end
   end

   always_comb begin
      case (paddr)
         OFS_CFG: prdata = {23'h0, cfg_q};
         OFS_CTRL: prdata = {31'h0, init_done_q};
         OFS_STAT: prdata = {23'h0, link.fault_count, link.deep_failsafe_state,
                             link.uv_flag, link.ov_flag, link.power_good_output,
                             link.reset_output_low};
         default: prdata = 32'h0;
      endcase
   end

   assign link.cfg_we = cfg_we_q;
   assign link.ov_impact = cfg_q[1:0];
   assign link.uv_impact = cfg_q[3:2];
   assign link.limit = cfg_q[5:4];
   assign link.reg_sel = cfg_q[8:6];
   assign link.init_done = init_done_q;
   assign link.pulse_req = pulse_q;
endmodule

// *** testbench/vmfc_link_monitor.sv ***
// Checker on the link between host end and monitor device.
// Assumes one pclk domain, presetn active low.
`timescale 1ns/1ps
module vmfc_link_monitor
   import vmfc_pkg::*;
(
   input logic pclk,
   input logic presetn,
   input logic cfg_we,
   input logic [1:0] ov_impact,
   input logic [1:0] uv_impact,
   input logic [1:0] limit,
   input logic init_done,
   input logic pulse_req,
   input logic reset_output_low,
   input logic power_good_output,
   input logic ov_flag,
   input logic uv_flag,
   input logic [3:0] fault_count,
   input logic deep_failsafe_state
);
   logic [5:0] cfg_q;
   logic [3:0] cnt_max;
   // Shadow of accepted settings; writes after init are dropped
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_q <= {LIMIT_RST, UV_IMPACT_RST, OV_IMPACT_RST};
      end else if (cfg_we && !init_done) begin
         cfg_q <= {limit, uv_impact, ov_impact};
      end
   end
   assign cnt_max = cfg_q[5] ? (cfg_q[4] ? LIMIT_12 : LIMIT_8) : (cfg_q[4] ? LIMIT_6 : LIMIT_2);
   default clocking @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   chk_pg_low_rst: assert property (!power_good_output |-> !reset_output_low)
      else $error("reset released while power-good low");
   chk_count_step: assert property ($changed(fault_count) |->
      fault_count == 4'h1 || fault_count == $past(fault_count) + 4'h1)
      else $error("counter moved by more than one");
   chk_deep_entry: assert property (fault_count == cnt_max |=> deep_failsafe_state)
      else $error("no deep fail-safe at limit");
   chk_deep_hold: assert property (deep_failsafe_state |=>
      deep_failsafe_state && !power_good_output && !reset_output_low)
      else $error("deep fail-safe left or outputs high");
   chk_pulse_reset: assert property (pulse_req |=> !reset_output_low)
      else $error("reset pulse missing");
   chk_pulse_nocount: assert property (pulse_req |=> $stable(fault_count))
      else $error("reset pulse counted");
   chk_ov_quiet: assert property ($rose(ov_flag) && !cfg_q[1] |-> $stable(fault_count))
      else $error("non-reset fault counted");
   chk_uv_count: assert property ($rose(uv_flag) && cfg_q[3] && $past(reset_output_low)
      && $past(fault_count) < cnt_max |-> fault_count == $past(fault_count) + 4'h1)
      else $error("reset fault not counted");
   chk_uv_reset: assert property ($rose(uv_flag) && cfg_q[3] |=> !reset_output_low)
      else $error("undervoltage did not assert reset");
   cov_pulse: cover property (pulse_req);
   cov_ov: cover property ($rose(ov_flag));
   cov_uv: cover property ($rose(uv_flag));
   cov_deep: cover property ($rose(deep_failsafe_state));
endmodule

// *** testbench/tb.sv ***
// Bench: host and device on one link, APB stimulus, read scoreboard.
// Assumes 40 MHz pclk and a zero-wait APB slave in the host end.
`timescale 1ns/1ps
module tb;
   import vmfc_pkg::*;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00, ov_thr = 8'h00, uv_thr = 8'h00, level = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata;
   logic pready, pslverr, ov_dg = 1'b0, uv_pg = 1'b0, standby = 1'b0, pgf = 1'b0;
   logic [1:0] uv_dg = 2'h0;
   logic [3:0] evt = 4'h0;
   logic [2:0] reg_off, rsel = 3'h1;
   logic [64:0] exp_q[$];
   logic [64:0] note;
   int miscompares = 0, compares = 0;
   always #12.5 pclk = ~pclk;
   vmfc_link_if i_vmfc_link_if();
   vmfc_device i_vmfc_device(.pclk(pclk), .presetn(presetn), .link(i_vmfc_link_if),
      .aux_enable_fuse(1'b1), .aux_ov_threshold_fuse(ov_thr), .aux_uv_threshold_fuse(uv_thr),
      .aux_ov_deglitch_fuse(ov_dg), .aux_uv_deglitch_fuse(uv_dg), .aux_ov_pg_fuse(1'b0),
      .aux_uv_pg_fuse(uv_pg), .power_good_follows_reset(pgf), .aux_level_pct2(level),
      .core_io_fault_rst(1'b0), .core_io_fault_pg(1'b0), .ext_reset_low(evt[0]),
      .reset_short_high(evt[1]), .register_corruption_flag(evt[2]),
      .fuse_corruption_flag(evt[3]), .standby_resume(standby), .regulator_off(reg_off));
   vmfc_host i_vmfc_host(.pclk(pclk), .presetn(presetn), .link(i_vmfc_link_if), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr));
   vmfc_link_monitor i_vmfc_link_monitor(.pclk(pclk), .presetn(presetn),
      .cfg_we(i_vmfc_link_if.cfg_we), .ov_impact(i_vmfc_link_if.ov_impact),
      .uv_impact(i_vmfc_link_if.uv_impact), .limit(i_vmfc_link_if.limit),
      .init_done(i_vmfc_link_if.init_done), .pulse_req(i_vmfc_link_if.pulse_req),
      .reset_output_low(i_vmfc_link_if.reset_output_low),
      .power_good_output(i_vmfc_link_if.power_good_output), .ov_flag(i_vmfc_link_if.ov_flag),
      .uv_flag(i_vmfc_link_if.uv_flag), .fault_count(i_vmfc_link_if.fault_count),
      .deep_failsafe_state(i_vmfc_link_if.deep_failsafe_state));
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic give_verdict();
      $display("Compares %0d, miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // Note for reads: {slave error, expected data, mask}
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
      input logic [64:0] nt);
      int n;
      @(posedge pclk);
      if (!w) exp_q.push_back(nt);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20) begin
         miscompares++;
         give_verdict();
      end
   endtask
   // Flag rises on the deglitch count-th edge after the level changes
   task automatic wait_flag(input logic uv, input logic [11:0] n_exp);
      int n;
      n = 0;
      do begin
         @(posedge pclk);
         #1;
         n++;
      end while ((uv ? i_vmfc_link_if.uv_flag : i_vmfc_link_if.ov_flag) !== 1'b1 && n < 2000);
      cmp(32'(n), 32'(n_exp));
      if (n >= 2000) give_verdict();
   endtask
   always @(posedge pclk) begin
      if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0) begin
         note = exp_q.pop_front();
         cmp({31'h0, pslverr}, {31'h0, note[64]});
         cmp(prdata & note[31:0], note[63:32]);
      end
   end
   initial begin
      logic [11:0] uvn[4];
      uvn = '{UV_DGLT_CYC_0, UV_DGLT_CYC_1, UV_DGLT_CYC_2, UV_DGLT_CYC_3};
      void'($urandom(66352));
      // Zero picks the external regulator, which is never switched off
      rsel = 3'($urandom_range(7, 0));
      pgf = 1'($urandom);
      ov_thr = 8'($urandom_range(15));
      uv_thr = 8'($urandom_range(15));
      ov_dg = 1'($urandom);
      uv_dg = 2'($urandom);
      uv_pg = 1'($urandom);
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, 8'h08, 32'h0, {1'b0, 32'h23, 32'h1ff});
      apb(1'b0, 8'h00, 32'h0, {1'b0, 32'h16, 32'h1ff});
      apb(1'b0, 8'h0c, 32'h0, {1'b1, 64'h0});
      apb(1'b1, 8'h00, {23'h0, rsel, 6'h28}, 65'h0);
      apb(1'b0, 8'h00, 32'h0, {1'b0, 23'h0, rsel, 6'h28, 32'h1ff});
      apb(1'b1, 8'h04, 32'h1, 65'h0);
      apb(1'b1, 8'h00, 32'h3f, 65'h0);
      apb(1'b1, 8'h04, 32'h2, 65'h0);
      apb(1'b0, 8'h08, 32'h0, {1'b0, 32'h22, 32'h1e2});
      level <= ov_thr + 8'h0a;
      wait_flag(1'b0, ov_dg ? OV_DGLT_CYC_1 : OV_DGLT_CYC_0);
      apb(1'b0, 8'h08, 32'h0, {1'b0, 32'h27, 32'h1e7});
      level <= 8'hf6 - uv_thr;
      wait_flag(1'b1, uvn[uv_dg]);
      apb(1'b0, 8'h08, 32'h0, {1'b0, (uv_pg || pgf) ? 32'h48 : 32'h4a, 32'h1eb});
      level <= 8'h00;
      for (int k = 0; k < 8; k++) begin
         @(posedge pclk);
         evt <= 4'h1 << (k % 4);
         @(posedge pclk);
         evt <= 4'h0;
         if (k == 3) apb(1'b0, 8'h08, 32'h0, {1'b0, 32'hc2, uv_pg ? 32'h1e0 : 32'h1e2});
      end
      apb(1'b0, 8'h08, 32'h0, {1'b0, 32'h110, 32'h1f3});
      @(posedge pclk);
      standby <= 1'b1;
      @(posedge pclk);
      standby <= 1'b0;
      apb(1'b0, 8'h08, 32'h0, {1'b0, 32'h30, 32'h1f0});
      cmp(32'(reg_off), 32'(rsel));
      give_verdict();
   end
endmodule
